// >>> src/hpm_mem.sv
// Dual-port word memory with registered read data on both ports.
// Assumes port A is the host port and port B the internal processor.
`timescale 1ns/1ps
`default_nettype none
module hpm_mem
    import hpm_pkg::*;
#(
    parameter int unsigned AW = 10
) (
    input wire logic clock,
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DATA_W-1:0] a_wdata,
    output logic [DATA_W-1:0] a_rdata,
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [DATA_W-1:0] b_wdata,
    output logic [DATA_W-1:0] b_rdata
);
    logic [DATA_W-1:0] mem [2**AW];

    // Same-address writes: the processor port lands last
    always_ff @(posedge clock) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule
`default_nettype wire

// >>> src/hpm_pkg.sv
// Constants and carrier types for the parallel host port block.
// Assumes one 20 MHz clock shared by every file of the block.
`default_nettype none
package hpm_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TEST_WINDOW_MS = 3;
    // Longest time, so the division rounds down
    localparam int unsigned TEST_CYCLES = TEST_WINDOW_MS * (CLK_HZ / 1000);
    localparam int unsigned TEST_CNT_W = 16;
    // Edges before the synchronised boot straps are trusted
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // ==========================================================
    // Port register select codes
    localparam int unsigned DATA_W = 16;
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_MBX = 2'h1;
    localparam logic [1:0] SEL_PTR = 2'h2;
    localparam logic [1:0] SEL_STAT = 2'h3;
    localparam logic [1:0] BOOT_PORT = 2'h0;

    // ==========================================================
    // Reset values and status layout
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [15:0] MBX_RST = 16'h0000;
    localparam logic [15:0] DUMMY_RD = 16'h0000;
    localparam int unsigned ST_OUT_FULL = 0;
    localparam int unsigned ST_IN_FULL = 1;
    localparam int unsigned ST_SLEEP = 2;
    localparam int unsigned ST_EN = 3;
    localparam int unsigned ST_TEST = 4;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_n;
        logic [1:0] sel;
        logic [15:0] data;
    } hpm_pins_t;

    localparam hpm_pins_t PINS_IDLE = '{rd_n: 1'h1, wr_n: 1'h1,
        cs_n: 1'h1, sel: 2'h0, data: 16'h0000};

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } hpm_mem_req_t;

endpackage
`default_nettype wire

// >>> src/hpm_port.sv
// Parallel host port: data window, mailbox, pointer and status.
// Assumes host pins are asynchronous; processor side shares clock.
//
// Overview of operation
// - Select code 00 is data, 01 mailbox, 10 pointer, 11 status.
// - Strobes are active low; a write is taken at its rising edge, a read fetches its word at the falling edge.
// - The interrupt output shows an outgoing mailbox word is waiting.
// - Every data register access outside sleep advances the address pointer by one.
// - Each access moves one 16-bit word over the data lines.
// - The mailbox carries words from host to processor and back.
// - Data register accesses reach memory at the pointer directly.
// - For 3 ms after boot the control and upper data pins drive a test mode.
// - The port stays disabled while a pin-sharing serial port is active.
// - Both boot straps low at reset release enable the port.
// - A read during sleep wakes the device and returns dummy data.
`timescale 1ns/1ps
`default_nettype none
module hpm_port
    import hpm_pkg::*;
#(
    parameter int unsigned MEM_AW = 10,
    parameter int unsigned TEST_LEN = TEST_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic port_select_n,
    input wire logic reg_select_hi,
    input wire logic reg_select_lo,
    input wire logic [DATA_W-1:0] port_data_in,
    output logic [DATA_W-1:0] port_data_out,
    output logic [DATA_W-1:0] port_data_oe_n,
    output logic port_int,
    output logic [4:0] test_ctrl_out,
    output logic [4:0] test_ctrl_oe_n,
    input wire logic [1:0] boot_select,
    input wire logic other_port_active,
    input wire logic sleep,
    output logic wake,
    output logic port_enabled,
    input wire hpm_mem_req_t cpu_mem_req,
    output logic [DATA_W-1:0] cpu_mem_rdata,
    input wire logic cpu_mbx_wr,
    input wire logic [DATA_W-1:0] cpu_mbx_wdata,
    input wire logic cpu_mbx_rd,
    output logic [DATA_W-1:0] cpu_mbx_rdata,
    output logic mbx_in_full,
    output logic mbx_out_full
);

    // ==========================================================
    // Parameter checks
    if (MEM_AW < 1 || MEM_AW > 16) begin : g_bad_aw
        $error("MEM_AW must lie in 1..16");
    end
    if (TEST_LEN < 1 || TEST_LEN >= 2**TEST_CNT_W) begin : g_bad_test
        $error("TEST_LEN does not fit the test counter");
    end

    // ==========================================================
    // Pin synchronisers
    hpm_pins_t pins_d;
    hpm_pins_t s;
    logic [1:0] boot_q;

    assign pins_d = '{rd_n: read_strobe_n, wr_n: write_strobe_n,
        cs_n: port_select_n, sel: {reg_select_hi, reg_select_lo},
        data: port_data_in};

    hpm_sync #(.W($bits(hpm_pins_t)), .INIT(PINS_IDLE)) u_pin_sync (
        .clock(clock),
        .reset(reset),
        .d(pins_d),
        .q(s)
    );

    hpm_sync #(.W(2), .INIT(2'h0)) u_boot_sync (
        .clock(clock),
        .reset(reset),
        .d(boot_select),
        .q(boot_q)
    );

    // ==========================================================
    // State
    hpm_pins_t p_r, p_nxt;
    logic [15:0] ptr_r, ptr_nxt;
    logic [15:0] mbx_in_r, mbx_in_nxt;
    logic [15:0] mbx_out_r, mbx_out_nxt;
    logic in_full_r, in_full_nxt;
    logic out_full_r, out_full_nxt;
    logic [15:0] rd_data_r, rd_data_nxt;
    logic rd_pend_r, rd_pend_nxt;
    logic wake_r, wake_nxt;
    logic [TEST_CNT_W-1:0] test_cnt_r, test_cnt_nxt;
    logic [1:0] strap_cnt_r, strap_cnt_nxt;
    logic strap_done_r, strap_done_nxt;
    logic boot_port_r, boot_port_nxt;

    logic test_active;
    logic port_en;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;
    logic mem_we;
    logic [15:0] mem_rdata;
    logic [15:0] status;

    // ==========================================================
    // Enable and edge detection
    assign test_active = (test_cnt_r != '0);
    assign port_en = boot_port_r & strap_done_r & ~other_port_active
        & ~test_active;
    // Rising edges use the previous sample so select and data precede them
    assign rd_fall = port_en & p_r.rd_n & ~s.rd_n & ~s.cs_n;
    assign rd_rise = port_en & ~p_r.rd_n & s.rd_n & ~p_r.cs_n;
    assign wr_rise = port_en & ~p_r.wr_n & s.wr_n & ~p_r.cs_n;
    assign mem_we = wr_rise & ~sleep & (p_r.sel == SEL_DATA);

    always_comb begin
        status = 16'h0000;
        status[ST_OUT_FULL] = out_full_r;
        status[ST_IN_FULL] = in_full_r;
        status[ST_SLEEP] = sleep;
        status[ST_EN] = port_en;
        status[ST_TEST] = test_active;
    end

    // ==========================================================
    // Next-state logic for the whole port
    always_comb begin
        p_nxt = s;
        ptr_nxt = ptr_r;
        mbx_in_nxt = mbx_in_r;
        mbx_out_nxt = mbx_out_r;
        in_full_nxt = in_full_r;
        out_full_nxt = out_full_r;
        rd_data_nxt = rd_data_r;
        rd_pend_nxt = 1'h0;
        wake_nxt = 1'h0;
        test_cnt_nxt = test_cnt_r;
        strap_cnt_nxt = strap_cnt_r;
        strap_done_nxt = strap_done_r;
        boot_port_nxt = boot_port_r;

        if (test_active) begin
            test_cnt_nxt = test_cnt_r - 1'h1;
        end

        if (!strap_done_r) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
            if (strap_cnt_r == STRAP_WAIT) begin
                strap_done_nxt = 1'h1;
                boot_port_nxt = (boot_q == BOOT_PORT);
            end
        end

        // Clears come first so a set wins: host set for incoming, processor set for outgoing
        if (cpu_mbx_rd) begin
            in_full_nxt = 1'h0;
        end
        if (rd_rise && !sleep && p_r.sel == SEL_MBX) begin
            out_full_nxt = 1'h0;
        end

        if (cpu_mbx_wr) begin
            mbx_out_nxt = cpu_mbx_wdata;
            out_full_nxt = 1'h1;
        end

        if (rd_fall) begin
            if (sleep) begin
                rd_data_nxt = DUMMY_RD;
            end else begin
                unique case (s.sel)
                    SEL_DATA: rd_pend_nxt = 1'h1;
                    SEL_MBX: rd_data_nxt = mbx_out_r;
                    SEL_PTR: rd_data_nxt = ptr_r;
                    SEL_STAT: rd_data_nxt = status;
                endcase
            end
        end
        if (rd_pend_r) begin
            rd_data_nxt = mem_rdata;
        end

        if (rd_rise && sleep) begin
            wake_nxt = 1'h1;
        end

        if ((rd_rise || wr_rise) && !sleep && p_r.sel == SEL_DATA) begin
            ptr_nxt = ptr_r + 16'h0001;
        end

        if (wr_rise && !sleep) begin
            unique case (p_r.sel)
                SEL_DATA: ;
                SEL_MBX: begin
                    mbx_in_nxt = p_r.data;
                    in_full_nxt = 1'h1;
                end
                SEL_PTR: ptr_nxt = p_r.data;
                SEL_STAT: ;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            p_r <= PINS_IDLE;
            ptr_r <= PTR_RST;
            mbx_in_r <= MBX_RST;
            mbx_out_r <= MBX_RST;
            in_full_r <= 1'h0;
            out_full_r <= 1'h0;
            rd_data_r <= DUMMY_RD;
            rd_pend_r <= 1'h0;
            wake_r <= 1'h0;
            test_cnt_r <= TEST_CNT_W'(TEST_LEN);
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'h0;
            boot_port_r <= 1'h0;
        end else begin
            p_r <= p_nxt;
            ptr_r <= ptr_nxt;
            mbx_in_r <= mbx_in_nxt;
            mbx_out_r <= mbx_out_nxt;
            in_full_r <= in_full_nxt;
            out_full_r <= out_full_nxt;
            rd_data_r <= rd_data_nxt;
            rd_pend_r <= rd_pend_nxt;
            wake_r <= wake_nxt;
            test_cnt_r <= test_cnt_nxt;
            strap_cnt_r <= strap_cnt_nxt;
            strap_done_r <= strap_done_nxt;
            boot_port_r <= boot_port_nxt;
        end
    end

    // ==========================================================
    // Shared memory
    hpm_mem #(.AW(MEM_AW)) u_mem (
        .clock(clock),
        .a_we(mem_we),
        .a_addr(ptr_r[MEM_AW-1:0]),
        .a_wdata(p_r.data),
        .a_rdata(mem_rdata),
        .b_we(cpu_mem_req.we),
        .b_addr(cpu_mem_req.addr[MEM_AW-1:0]),
        .b_wdata(cpu_mem_req.wdata),
        .b_rdata(cpu_mem_rdata)
    );

    // ==========================================================
    // Outputs
    logic host_reading;
    // Drive while the host holds a read open; the upper byte also during test mode
    assign host_reading = port_en & ~s.cs_n & ~s.rd_n;
    assign port_data_out = rd_data_r;
    assign port_data_oe_n = {{8{~(host_reading | test_active)}},
        {8{~host_reading}}};
    assign test_ctrl_oe_n = {5{~test_active}};
    assign test_ctrl_out = 5'h00;
    assign port_int = out_full_r;
    assign wake = wake_r;
    assign port_enabled = port_en;
    assign cpu_mbx_rdata = mbx_in_r;
    assign mbx_in_full = in_full_r;
    assign mbx_out_full = out_full_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_int_on_msg;
        cpu_mbx_wr |=> port_int;
    endproperty
    a_int_on_msg: assert property (p_int_on_msg)
        else $error("interrupt missing after outgoing word");

    property p_ptr_step;
        (wr_rise || rd_rise) && !sleep && p_r.sel == SEL_DATA
            |=> ptr_r == $past(ptr_r) + 16'h0001;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("pointer did not advance");

    property p_sel_ptr;
        wr_rise && !sleep && p_r.sel == SEL_PTR |=> ptr_r == $past(p_r.data);
    endproperty
    a_sel_ptr: assert property (p_sel_ptr)
        else $error("pointer write lost");

    property p_edge_only;
        !wr_rise |=> $stable(mbx_in_r);
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("mailbox changed without write edge");

    property p_mbx_out;
        rd_fall && !sleep && s.sel == SEL_MBX
            |=> port_data_out == $past(mbx_out_r);
    endproperty
    a_mbx_out: assert property (p_mbx_out)
        else $error("outgoing mailbox word wrong");

    property p_mem_direct;
        wr_rise && !sleep && p_r.sel == SEL_DATA |-> mem_we;
    endproperty
    a_mem_direct: assert property (p_mem_direct)
        else $error("data write missed memory");

    property p_read_word;
        rd_fall && !sleep && s.sel == SEL_DATA |=> rd_pend_r ##1
            port_data_out == $past(mem_rdata);
    endproperty
    a_read_word: assert property (p_read_word)
        else $error("data word not returned");

    property p_test_end;
        $fell(test_active) |-> test_ctrl_oe_n == 5'h1F;
    endproperty
    a_test_end: assert property (p_test_end)
        else $error("test drive outlived window");

    property p_exclusive;
        other_port_active |-> port_data_oe_n == 16'hFFFF || test_active;
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("port drove while shared pins busy");

    property p_boot_gate;
        port_en |-> boot_port_r;
    endproperty
    a_boot_gate: assert property (p_boot_gate)
        else $error("port enabled without boot straps");

    property p_sleep_read;
        rd_rise && sleep |=> wake && $stable(ptr_r);
    endproperty
    a_sleep_read: assert property (p_sleep_read)
        else $error("sleeping read misbehaved");

endmodule
`default_nettype wire

// >>> src/hpm_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes the group is only sampled, never combined before stage two.
`timescale 1ns/1ps
`default_nettype none
module hpm_sync
    import hpm_pkg::*;
#(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Stage one feeds stage two only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> tb/hpm_host_model.sv
// Host processor model driving the parallel host port pins.
// Assumes one clock shared with the port; strobes change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module hpm_host_model
    import hpm_pkg::*;
(
    input wire logic clock,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic port_select_n,
    output logic reg_select_hi,
    output logic reg_select_lo,
    output logic [DATA_W-1:0] port_data_in,
    input wire logic [DATA_W-1:0] port_data_out,
    input wire logic [DATA_W-1:0] port_data_oe_n
);
    hpm_pins_t pins_r = PINS_IDLE;
    logic drv_r = 1'b0;
    logic [DATA_W-1:0] last_r = 16'h0000;

    // ==========================================================
    // Pin fan-out
    // select code order
    assign read_strobe_n = pins_r.rd_n;
    assign write_strobe_n = pins_r.wr_n;
    assign port_select_n = pins_r.cs_n;
    assign reg_select_hi = pins_r.sel[1];
    assign reg_select_lo = pins_r.sel[0];

    // Wire level; an undriven bit toggles so stale data cannot pass
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            if (drv_r) begin
                port_data_in[i] = pins_r.data[i];
            end else if (!port_data_oe_n[i]) begin
                port_data_in[i] = port_data_out[i];
            end else begin
                port_data_in[i] = ~last_r[i];
            end
        end
    end

    // Last level seen on the wire
    always_ff @(posedge clock) begin
        last_r <= port_data_in;
    end

    // ==========================================================
    // One access: one 16-bit word, select held through the rising strobe
    // strobe timing
    task automatic acc(input logic wr, input logic [1:0] sel,
        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
        @(negedge clock);
        pins_r.sel = sel;
        pins_r.data = wd;
        drv_r = wr;
        repeat (3) @(negedge clock);
        pins_r.cs_n = 1'b0;
        pins_r.wr_n = ~wr;
        pins_r.rd_n = wr;
        // Read the wire, not the output, so a missing enable shows
        repeat (6) @(negedge clock);
        rd = port_data_in;
        pins_r.rd_n = 1'b1;
        pins_r.wr_n = 1'b1;
        repeat (3) @(negedge clock);
        pins_r.cs_n = 1'b1;
        drv_r = 1'b0;
        repeat (2) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the parallel host port.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hpm_pkg::*;
;
    localparam int unsigned TLEN = 20;
    logic clock;
    logic reset;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic sel_hi;
    logic sel_lo;
    logic [DATA_W-1:0] d_in;
    logic [DATA_W-1:0] d_out;
    logic [DATA_W-1:0] d_oe_n;
    logic [DATA_W-1:0] cpu_rdata;
    logic [DATA_W-1:0] mbx_rdata;
    logic [DATA_W-1:0] mbx_wdata;
    logic [4:0] tc_out;
    logic [4:0] tc_oe_n;
    logic [1:0] boot_select;
    logic port_int;
    logic wake;
    logic port_enabled;
    logic in_full;
    logic out_full;
    logic sleep;
    logic other_act;
    logic mbx_wr;
    logic mbx_rd;
    hpm_mem_req_t mem_req;
    int fails = 0;
    int n_compared = 0;
    int n_wake = 0;

    // ==========================================================
    // Clock, design and host
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    hpm_port #(.MEM_AW(10), .TEST_LEN(TLEN)) i_hpm_port (
        .clock(clock), .reset(reset), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .port_select_n(cs_n),
        .reg_select_hi(sel_hi), .reg_select_lo(sel_lo),
        .port_data_in(d_in), .port_data_out(d_out),
        .port_data_oe_n(d_oe_n), .port_int(port_int),
        .test_ctrl_out(tc_out), .test_ctrl_oe_n(tc_oe_n),
        .boot_select(boot_select), .other_port_active(other_act),
        .sleep(sleep), .wake(wake), .port_enabled(port_enabled),
        .cpu_mem_req(mem_req), .cpu_mem_rdata(cpu_rdata),
        .cpu_mbx_wr(mbx_wr), .cpu_mbx_wdata(mbx_wdata),
        .cpu_mbx_rd(mbx_rd), .cpu_mbx_rdata(mbx_rdata),
        .mbx_in_full(in_full), .mbx_out_full(out_full));

    hpm_host_model i_hpm_host_model (
        .clock(clock), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .port_select_n(cs_n), .reg_select_hi(sel_hi),
        .reg_select_lo(sel_lo), .port_data_in(d_in),
        .port_data_out(d_out), .port_data_oe_n(d_oe_n));

    // Wake is a single-cycle pulse; sample it off the edge that moves it
    always @(negedge clock) begin
        if (wake === 1'b1) n_wake++;
    end

    // ==========================================================
    // Checking and access tasks
    task automatic check(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic hw(input logic [1:0] sel, input logic [15:0] d);
        logic [15:0] dummy;
        i_hpm_host_model.acc(1'b1, sel, d, dummy);
    endtask

    task automatic rchk(input logic [1:0] sel, input logic [15:0] exp,
        input string nm);
        logic [15:0] v;
        i_hpm_host_model.acc(1'b0, sel, 16'h0000, v);
        check(nm, v, exp);
    endtask

    task automatic memchk(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clock);
        mem_req = '{we: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge clock);
        check("memory", cpu_rdata, exp);
    endtask

    // Reset, look at the test-mode drive, then let the window lapse
    task automatic restart(input logic [1:0] bs);
        @(negedge clock);
        reset = 1'b1;
        boot_select = bs;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        check("test oe", {11'h000, tc_oe_n}, 16'h0000);
        check("upper oe", {8'h00, d_oe_n[15:8]}, 16'h0000);
        check("test drive", {11'h000, tc_out}, 16'h0000);
        repeat (TLEN + 8) @(negedge clock);
        check("test oe end", {11'h000, tc_oe_n}, 16'h001F);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("wrong value run time expected finish seen hang");
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        boot_select = BOOT_PORT;
        sleep = 1'b0;
        other_act = 1'b0;
        mbx_wr = 1'b0;
        mbx_rd = 1'b0;
        mbx_wdata = 16'h0000;
        mem_req = '0;
        restart(BOOT_PORT);
        check("enabled", {15'h0000, port_enabled}, 16'h0001);
        rchk(SEL_STAT, 16'h0008, "status");
        hw(SEL_PTR, 16'h03FF);
        rchk(SEL_PTR, 16'h03FF, "pointer");
        hw(SEL_DATA, 16'hBEEF);
        hw(SEL_DATA, 16'h1357);
        rchk(SEL_PTR, 16'h0401, "pointer");
        memchk(16'h03FF, 16'hBEEF);
        memchk(16'h0000, 16'h1357);
        @(negedge clock);
        mem_req = '{we: 1'b1, addr: 16'h0001, wdata: 16'h2468};
        @(negedge clock);
        mem_req.we = 1'b0;
        hw(SEL_PTR, 16'h0000);
        rchk(SEL_DATA, 16'h1357, "data");
        rchk(SEL_DATA, 16'h2468, "data");
        rchk(SEL_PTR, 16'h0002, "pointer");
        // Mailbox both ways
        hw(SEL_MBX, 16'hA5C3);
        check("in full", {15'h0000, in_full}, 16'h0001);
        check("incoming", mbx_rdata, 16'hA5C3);
        mbx_rd = 1'b1;
        @(negedge clock);
        mbx_rd = 1'b0;
        @(negedge clock);
        check("in full", {15'h0000, in_full}, 16'h0000);
        mbx_wdata = 16'h5A3C;
        mbx_wr = 1'b1;
        @(negedge clock);
        mbx_wr = 1'b0;
        @(negedge clock);
        check("interrupt", {15'h0000, port_int}, 16'h0001);
        check("out full", {15'h0000, out_full}, 16'h0001);
        rchk(SEL_STAT, 16'h0009, "status");
        rchk(SEL_MBX, 16'h5A3C, "outgoing");
        check("interrupt", {15'h0000, port_int}, 16'h0000);
        check("out full", {15'h0000, out_full}, 16'h0000);
        // Status is read-only
        hw(SEL_STAT, 16'hFFFF);
        rchk(SEL_STAT, 16'h0008, "status");
        // Read in sleep wakes and gives a throwaway word
        sleep = 1'b1;
        hw(SEL_PTR, 16'h0055);
        rchk(SEL_PTR, DUMMY_RD, "dummy");
        sleep = 1'b0;
        check("wakes", n_wake[15:0], 16'h0001);
        rchk(SEL_PTR, 16'h0002, "pointer");
        // Pin-sharing port active locks the host out
        other_act = 1'b1;
        @(negedge clock);
        check("enabled", {15'h0000, port_enabled}, 16'h0000);
        hw(SEL_PTR, 16'h0077);
        other_act = 1'b0;
        @(negedge clock);
        rchk(SEL_PTR, 16'h0002, "pointer");
        // Other strap pattern leaves the port off
        restart(2'h1);
        check("enabled", {15'h0000, port_enabled}, 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
